// file: arpf_pkg.sv
`default_nettype none
package arpf_pkg;
   // Quadlet and field geometry
   localparam int QW          = 32;
   localparam int ID_W        = 16;
   localparam int BUS_W       = 10;
   localparam int NODE_W      = 6;
   localparam int LABEL_W     = 6;
   localparam int RETRY_W     = 2;
   localparam int TRANSACTION_CODE_W     = 4;
   localparam int PRIO_W      = 4;
   localparam int OFFU_W      = 16;
   localparam int RCODE_W     = 4;
   localparam int SPEED_W     = 2;
   localparam int ACK_W       = 4;
   localparam int BYTE_W      = 8;
   localparam int BYTES_PER_Q = 4;
   // Bit positions inside quadlets (LSB numbering)
   localparam int RCODE_LSB   = 12;
   localparam int SPEED_LSB   = 16;
   localparam int ACK_LSB     = 0;
   localparam int LABEL_LSB   = 10;
   localparam int TRANSACTION_CODE_LSB   = 4;
   // Transaction codes
   localparam logic [3:0] TC_WR_QUAD    = 4'h0;
   localparam logic [3:0] TC_WR_BLOCK   = 4'h1;
   localparam logic [3:0] TC_RD_QUAD    = 4'h4;
   localparam logic [3:0] TC_RD_BLOCK   = 4'h5;
   localparam logic [3:0] TC_RDQ_RESP   = 4'h6;
   localparam logic [3:0] TC_RDB_RESP   = 4'h7;
   localparam logic [3:0] TC_LOCK_REQ   = 4'h9;
   localparam logic [3:0] TC_LOCK_RESP  = 4'hb;
   // Speed codes; 2'h3 is never emitted
   localparam logic [1:0] SPD_100       = 2'h0;
   localparam logic [1:0] SPD_200       = 2'h1;
   localparam logic [1:0] SPD_400       = 2'h2;
   // Receive FIFO depth
   localparam int RXQ_DEPTH   = 4;
   // Host register map (byte addresses) and AXI responses
   localparam logic [3:0] REG_CTRL      = 4'h0;
   localparam logic [3:0] REG_STATUS    = 4'h4;
   localparam logic [3:0] REG_DATA      = 4'h8;
   localparam logic [3:0] REG_LABEL     = 4'hc;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage
`default_nettype wire

// file: arpf_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface arpf_link_if;
   import arpf_pkg::*;
   logic          q_valid;  // Quadlet waiting in receive FIFO
   logic [QW-1:0] q_data;   // Head quadlet
   logic          q_last;   // Head is the packet's status quadlet
   logic          q_ready;  // Host pops the head
   modport dev  (output q_valid, q_data, q_last, input q_ready);
   modport host (input q_valid, q_data, q_last, output q_ready);
endinterface
`default_nettype wire

// file: arpf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module arpf_fifo #(
   parameter int DW    = 33,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_rstn,
   // Fill side
   input  wire logic          i_valid,
   input  wire logic [DW-1:0] i_data,
   output var  logic          o_ready,
   // Drain side
   output var  logic          o_valid,
   output var  logic [DW-1:0] o_data,
   input  wire logic          i_ready
);
   localparam int CW = $clog2(DEPTH + 1);
   if (DEPTH < 2 || DW < 1) begin : g_chk
      $error("arpf_fifo: DEPTH must be at least 2");
   end
   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] mem;
      logic [CW-1:0]            cnt;
      logic                     valid;
      logic                     ready;
   } arpf_fifo_st_t;
   arpf_fifo_st_t s, next_s;

   // Shift FIFO: head always sits in slot 0, so outputs are flops
   always_comb begin
      next_s = s;
      if (s.valid && i_ready) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            next_s.mem[i] = s.mem[i + 1];
         end
         next_s.cnt = s.cnt - CW'(1);
      end
      if (i_valid && s.ready) begin
         next_s.mem[next_s.cnt] = i_data;
         next_s.cnt = next_s.cnt + CW'(1);
      end
      next_s.valid = (next_s.cnt != '0);
      next_s.ready = (next_s.cnt != CW'(DEPTH)); // Honest full
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         s <= '{mem: '0, cnt: '0, valid: 1'b0, ready: 1'b1};
      end else begin
         s <= next_s;
      end
   end

   assign o_ready = s.ready;
   assign o_valid = s.valid;
   assign o_data  = s.mem[0];
endmodule // arpf_fifo
`default_nettype wire

// file: arpf_device.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Target ident high, control fields low, quadlet one
// - Sender ident high, offset fills rest
// - Quadlet data only for writes, read responses
// - Status quadlet appended after every packet
// - Status holds speed and returned acknowledge
// - Speed codes 00/01/10; never emit 11
// - Retry code passed through unchanged
// - Target ident is bus then node number
// - Sender zeroes priority on cable buses
// - Sender keeps offset quadlet aligned
// - Lock response: top four offset bits rcode
// - Transaction label kept unchanged for matching
// - Block data for writes, read responses, lock requests and lock responses
// - Control order: label, retry, transaction_code, priority
// - Byte count excludes header, payload only
// - First byte in byte 0, zero pad
module arpf_device
   import arpf_pkg::*;
#(
   parameter int FIFO_DEPTH = RXQ_DEPTH
) (
   // Clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_rstn,
   // Received packet descriptor
   input  wire logic                i_pkt_valid,
   output var  logic                o_pkt_ready,
   input  wire logic [BUS_W-1:0]    i_bus_number,
   input  wire logic [NODE_W-1:0]   i_node_number,
   input  wire logic [LABEL_W-1:0]  i_transaction_label,
   input  wire logic [RETRY_W-1:0]  i_retry_code,
   input  wire logic [TRANSACTION_CODE_W-1:0]  i_transaction_code,
   input  wire logic [PRIO_W-1:0]   i_priority,
   input  wire logic [ID_W-1:0]     i_sender_node_ident,
   input  wire logic [OFFU_W-1:0]   i_target_offset_upper,
   input  wire logic [QW-1:0]       i_target_offset_lower,
   input  wire logic [QW-1:0]       i_quadlet_data,
   input  wire logic [ID_W-1:0]     i_payload_byte_count,
   input  wire logic [ID_W-1:0]     i_block_operation_code,
   input  wire logic [SPEED_W-1:0]  i_speed,
   input  wire logic [ACK_W-1:0]    i_returned_acknowledge,
   // Block payload bytes, first byte first
   input  wire logic                i_byte_valid,
   input  wire logic [BYTE_W-1:0]   i_byte,
   output var  logic                o_byte_ready,
   // Host side of the receive FIFO
   arpf_link_if.dev                 link
);
   if (FIFO_DEPTH < 2) begin : g_chk
      $error("arpf_device: FIFO_DEPTH must be at least 2");
   end

   typedef enum logic [1:0] {
      ST_IDLE, ST_HDR, ST_DATA, ST_STAT
   } arpf_state_t;

   typedef struct packed {
      arpf_state_t         state;
      logic [3:0][QW-1:0]  hdr;      // Header quadlets, in order
      logic [1:0]          qi;       // Next header quadlet
      logic [1:0]          q_end;    // Last header quadlet index
      logic                has_data; // Block payload follows header
      logic [ID_W-1:0]     left;     // Payload bytes still to come
      logic [QW-1:0]       word;     // Payload quadlet being built
      logic [1:0]          pos;      // Byte lane inside word
      logic [QW-1:0]       stat;     // Status quadlet
      logic                wr_valid;
      logic [QW-1:0]       wr_data;
      logic                wr_last;
      logic                pkt_ready;
      logic                byte_ready;
   } arpf_dev_st_t;

   arpf_dev_st_t s, next_s;
   logic         fifo_ready;

   // Format decode from transaction code, plus speed code mapping
   logic is_block;
   logic quad_data;
   logic block_data;
   logic [OFFU_W-1:0] offu;
   logic [SPEED_W-1:0] spd;
   always_comb begin
      is_block   = (i_transaction_code == TC_WR_BLOCK)  ||
                   (i_transaction_code == TC_RD_BLOCK)  ||
                   (i_transaction_code == TC_RDB_RESP)  ||
                   (i_transaction_code == TC_LOCK_REQ)  ||
                   (i_transaction_code == TC_LOCK_RESP);
      quad_data  = (i_transaction_code == TC_WR_QUAD)   ||
                   (i_transaction_code == TC_RDQ_RESP);
      // Block read requests carry a byte count but no payload
      block_data = is_block && (i_transaction_code != TC_RD_BLOCK) &&
                   (i_payload_byte_count != '0);
      offu = i_target_offset_upper;
      if (i_transaction_code == TC_LOCK_RESP) begin
         offu[RCODE_LSB-1:0] = '0;
      end
      // Undefined speed code is never passed on; slowest is safest
      spd = (i_speed == SPD_400) ? SPD_400 :
            (i_speed == SPD_200) ? SPD_200 : SPD_100;
   end

   // Packet formatting sequence
   always_comb begin
      next_s = s;
      if (s.wr_valid && fifo_ready) begin
         next_s.wr_valid = 1'b0;
      end
      unique case (s.state)
         ST_IDLE: begin
            if (s.pkt_ready && i_pkt_valid) begin
               next_s.hdr[0] = {i_bus_number, i_node_number,
                                i_transaction_label,
                                i_retry_code,
                                i_transaction_code,
                                i_priority};
               next_s.hdr[1] = {i_sender_node_ident, offu};
               next_s.hdr[2] = i_target_offset_lower;
               next_s.hdr[3] = is_block ?
                  {i_payload_byte_count, i_block_operation_code}
                  : i_quadlet_data;
               next_s.q_end    = (is_block || quad_data) ? 2'd3 : 2'd2;
               next_s.has_data = block_data;
               next_s.left     = i_payload_byte_count;
               next_s.word     = '0;
               next_s.pos      = '0;
               next_s.qi       = '0;
               next_s.stat     = '0;
               next_s.stat[SPEED_LSB +: SPEED_W] = spd;
               next_s.stat[ACK_LSB +: ACK_W] =
                  i_returned_acknowledge;
               next_s.state    = ST_HDR;
            end
         end
         ST_HDR: begin
            if (!next_s.wr_valid) begin
               next_s.wr_valid = 1'b1;
               next_s.wr_data  = s.hdr[s.qi];
               next_s.wr_last  = 1'b0;
               next_s.qi       = s.qi + 2'd1;
               if (s.qi == s.q_end) begin
                  next_s.state = s.has_data ? ST_DATA : ST_STAT;
               end
            end
         end
         ST_DATA: begin
            // Bytes only flow while no quadlet waits for the FIFO
            if (s.byte_ready && i_byte_valid) begin
               next_s.word[QW-1-BYTE_W*s.pos -: BYTE_W] = i_byte;
               next_s.left = s.left - ID_W'(1);
               next_s.pos  = s.pos + 2'd1;
               if (s.pos == 2'(BYTES_PER_Q - 1) || s.left == ID_W'(1)) begin
                  // Unfilled lanes stay zero as padding
                  next_s.wr_valid = 1'b1;
                  next_s.wr_data  = next_s.word;
                  next_s.wr_last  = 1'b0;
                  next_s.word     = '0;
                  next_s.pos      = '0;
                  if (s.left == ID_W'(1)) begin
                     next_s.state = ST_STAT;
                  end
               end
            end
         end
         ST_STAT: begin
            if (!next_s.wr_valid) begin
               next_s.wr_valid = 1'b1;
               next_s.wr_data  = s.stat;
               next_s.wr_last  = 1'b1;
               next_s.state    = ST_IDLE;
            end
         end
      endcase
      // Ready flags are registered; they look at the coming state
      next_s.pkt_ready  = (next_s.state == ST_IDLE) &&
                          !(s.pkt_ready && i_pkt_valid);
      next_s.byte_ready = (next_s.state == ST_DATA) && !next_s.wr_valid;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         s <= '{state: ST_IDLE, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign o_pkt_ready  = s.pkt_ready;
   assign o_byte_ready = s.byte_ready;

   // Receive FIFO; its fullness stalls the formatter
   arpf_fifo #(
      .DW    (QW + 1),
      .DEPTH (FIFO_DEPTH)
   ) u_rxq (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_valid (s.wr_valid),
      .i_data  ({s.wr_last, s.wr_data}),
      .o_ready (fifo_ready),
      .o_valid (link.q_valid),
      .o_data  ({link.q_last, link.q_data}),
      .i_ready (link.q_ready)
   );
endmodule // arpf_device
`default_nettype wire

// file: arpf_host.sv
`timescale 1ns/1ps
`default_nettype none
module arpf_host
   import arpf_pkg::*;
(
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_rstn,
   // AXI4-Lite write
   input  wire logic          i_awvalid,
   output var  logic          o_awready,
   input  wire logic [3:0]    i_awaddr,
   input  wire logic          i_wvalid,
   output var  logic          o_wready,
   input  wire logic [QW-1:0] i_wdata,
   input  wire logic [3:0]    i_wstrb,
   output var  logic          o_bvalid,
   input  wire logic          i_bready,
   output var  logic [1:0]    o_bresp,
   // AXI4-Lite read
   input  wire logic          i_arvalid,
   output var  logic          o_arready,
   input  wire logic [3:0]    i_araddr,
   output var  logic          o_rvalid,
   input  wire logic          i_rready,
   output var  logic [QW-1:0] o_rdata,
   output var  logic [1:0]    o_rresp,
   // Receive FIFO of the formatter
   arpf_link_if.host          link
);
   typedef struct packed {
      logic               awready;
      logic               wready;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               arready;
      logic               rvalid;
      logic [QW-1:0]      rdata;
      logic [1:0]         rresp;
      logic               enable;
      logic [LABEL_W-1:0] exp_label;
      logic               match;
      logic [1:0]         qidx;     // Quadlet position in packet
      logic [TRANSACTION_CODE_W-1:0] transaction_code;
      logic [RCODE_W-1:0] rcode;
      logic               q_ready;
   } arpf_host_st_t;
   arpf_host_st_t s, next_s;

   // Register slave and FIFO reader
   always_comb begin
      next_s = s;
      next_s.q_ready = 1'b0;
      // Write: both channels taken on the same edge
      next_s.awready = i_awvalid && i_wvalid && !s.bvalid && !s.awready;
      next_s.wready  = next_s.awready;
      if (s.awready) begin
         next_s.bvalid = 1'b1;
         next_s.bresp  = RESP_OKAY;
         if (i_wstrb[0] && i_awaddr == REG_CTRL) begin
            next_s.enable = i_wdata[0];
         end else if (i_wstrb[0] && i_awaddr == REG_LABEL) begin
            next_s.exp_label = i_wdata[LABEL_W-1:0];
         end else if (i_awaddr != REG_CTRL && i_awaddr != REG_LABEL) begin
            next_s.bresp = RESP_SLVERR;
         end
      end
      if (s.bvalid && i_bready) begin
         next_s.bvalid = 1'b0;
      end
      // Read: one-cycle address pulse, data the cycle after
      next_s.arready = i_arvalid && !s.rvalid && !s.arready;
      if (s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = RESP_OKAY;
         next_s.rdata  = '0;
         unique case (i_araddr)
            REG_CTRL:   next_s.rdata[0] = s.enable;
            REG_LABEL:  next_s.rdata[LABEL_W-1:0] = s.exp_label;
            REG_STATUS: next_s.rdata = {20'h0, s.rcode, 5'h0,
                                        s.match, link.q_last,
                                        link.q_valid};
            REG_DATA: begin
               // Disabled or empty reads return zero, pop nothing
               if (s.enable && link.q_valid) begin
                  next_s.rdata   = link.q_data;
                  next_s.q_ready = 1'b1;
                  next_s.qidx    = link.q_last ? 2'd0 :
                                   (s.qidx == 2'd3 ? 2'd3 : s.qidx + 2'd1);
                  if (s.qidx == 2'd0 && !link.q_last) begin
                     next_s.transaction_code = link.q_data[TRANSACTION_CODE_LSB +: TRANSACTION_CODE_W];
                     next_s.match = (link.q_data[LABEL_LSB +: LABEL_W] ==
                                     s.exp_label);
                  end
                  if (s.qidx == 2'd1 && s.transaction_code == TC_LOCK_RESP) begin
                     // Reserved offset bits are not looked at
                     next_s.rcode =
                        link.q_data[RCODE_LSB +: RCODE_W];
                  end
               end
            end
            default:    next_s.rresp = RESP_SLVERR;
         endcase
      end
      if (s.rvalid && i_rready) begin
         next_s.rvalid = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_awready    = s.awready;
   assign o_wready     = s.wready;
   assign o_bvalid     = s.bvalid;
   assign o_bresp      = s.bresp;
   assign o_arready    = s.arready;
   assign o_rvalid     = s.rvalid;
   assign o_rdata      = s.rdata;
   assign o_rresp      = s.rresp;
   assign link.q_ready = s.q_ready;
endmodule // arpf_host
`default_nettype wire

// file: arpf_chk.sv
`timescale 1ns/1ps
`default_nettype none
module arpf_chk
   import arpf_pkg::*;
(
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_rstn,
   // Receive FIFO link
   input  wire logic          q_valid,
   input  wire logic [QW-1:0] q_data,
   input  wire logic          q_last,
   input  wire logic          q_ready
);
   logic [2:0]         cnt;
   logic [TRANSACTION_CODE_W-1:0] tc;
   wire  logic         pop = q_valid && q_ready;
   // Position in packet; saturates so payload never looks like a header
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         cnt <= '0;
         tc  <= '0;
      end else if (pop) begin
         cnt <= q_last ? 3'h0 : (cnt == 3'h7 ? cnt : cnt + 3'h1);
         if (cnt == 3'h0) tc <= q_data[TRANSACTION_CODE_LSB +: TRANSACTION_CODE_W];
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   property p_hold;
      q_valid && !q_ready |=> q_valid && $stable(q_data) && $stable(q_last);
   endproperty
   a_hold: assert property (p_hold)
      else $error("head changed before pop");
   property p_pulse;
      q_ready |=> !q_ready;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("pop not a single pulse");
   property p_popv;
      q_ready |-> q_valid;
   endproperty
   a_popv: assert property (p_popv)
      else $error("pop with empty FIFO");
   property p_speed;
      q_valid && q_last |-> q_data[17:16] != 2'h3;
   endproperty
   a_speed: assert property (p_speed)
      else $error("undefined speed code");
   property p_stfmt;
      q_valid && q_last |-> q_data[31:18] == '0 && q_data[15:4] == '0;
   endproperty
   a_stfmt: assert property (p_stfmt)
      else $error("status quadlet layout");
   property p_hdr;
      q_valid && q_last |-> cnt >= 3'h3;
   endproperty
   a_hdr: assert property (p_hdr)
      else $error("status before full header");
   property p_lock;
      q_valid && cnt == 3'h1 && tc == TC_LOCK_RESP |-> q_data[11:0] == '0;
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock reserved offset bits set");
   property p_rdq;
      q_valid && cnt == 3'h3 && tc == TC_RD_QUAD |-> q_last;
   endproperty
   a_rdq: assert property (p_rdq)
      else $error("read request carries data");
   property p_wrq;
      q_valid && cnt == 3'h4 && tc == TC_WR_QUAD |-> q_last;
   endproperty
   a_wrq: assert property (p_wrq)
      else $error("quadlet write too long");
   property p_rdb;
      q_valid && cnt == 3'h4 && tc == TC_RD_BLOCK |-> q_last;
   endproperty
   a_rdb: assert property (p_rdb)
      else $error("block read carries data");
endmodule // arpf_chk
`default_nettype wire

// file: async_receive_packet_formatter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module async_receive_packet_formatter_tb_top;
   import arpf_pkg::*;
   logic                i_clk = 1'b0;
   logic                i_rstn = 1'b0;
   logic                i_pkt_valid, i_byte_valid, i_awvalid, i_wvalid;
   logic                i_bready, i_arvalid, i_rready;
   logic [BUS_W-1:0]    i_bus_number;
   logic [NODE_W-1:0]   i_node_number;
   logic [LABEL_W-1:0]  i_transaction_label;
   logic [RETRY_W-1:0]  i_retry_code;
   logic [TRANSACTION_CODE_W-1:0]  i_transaction_code;
   logic [PRIO_W-1:0]   i_priority;
   logic [ID_W-1:0]     i_sender_node_ident, i_target_offset_upper;
   logic [ID_W-1:0]     i_payload_byte_count, i_block_operation_code;
   logic [QW-1:0]       i_target_offset_lower, i_quadlet_data, i_wdata;
   logic [SPEED_W-1:0]  i_speed;
   logic [ACK_W-1:0]    i_returned_acknowledge;
   logic [BYTE_W-1:0]   i_byte;
   logic [3:0]          i_awaddr, i_wstrb, i_araddr;
   logic                o_pkt_ready, o_byte_ready, o_awready, o_wready;
   logic                o_bvalid, o_arready, o_rvalid;
   logic [1:0]          o_bresp, o_rresp;
   logic [QW-1:0]       o_rdata;
   logic [QW-1:0]       exq[$];
   int                  failures = 0;
   int                  comparisons = 0;
   // Free-running bench clock
   always #25 i_clk = ~i_clk;
   arpf_link_if arpf_link_if_inst ();
   arpf_device #(.FIFO_DEPTH(RXQ_DEPTH)) arpf_device_inst (
      .i_clk, .i_rstn, .i_pkt_valid, .o_pkt_ready, .i_bus_number,
      .i_node_number, .i_transaction_label, .i_retry_code,
      .i_transaction_code, .i_priority, .i_sender_node_ident,
      .i_target_offset_upper, .i_target_offset_lower, .i_quadlet_data,
      .i_payload_byte_count, .i_block_operation_code, .i_speed,
      .i_returned_acknowledge, .i_byte_valid, .i_byte, .o_byte_ready,
      .link(arpf_link_if_inst));
   arpf_host arpf_host_inst (
      .i_clk, .i_rstn, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
      .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp,
      .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata,
      .o_rresp, .link(arpf_link_if_inst));
   arpf_chk arpf_chk_inst (
      .i_clk, .i_rstn, .q_valid(arpf_link_if_inst.q_valid),
      .q_data(arpf_link_if_inst.q_data), .q_last(arpf_link_if_inst.q_last),
      .q_ready(arpf_link_if_inst.q_ready));
   task automatic complete_run;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cmp(input logic [QW-1:0] got, want, input string what);
      comparisons++;
      if (got !== want) begin
         failures++;
         $display("unexpected %0t %s got %h want %h", $time, what, got, want);
      end
   endtask
   // Single write and read transfers; address and data released as each is taken
   task automatic wr(input logic [3:0] a, input logic [QW-1:0] d,
                     input logic [1:0] want);
      bit aw, w;
      aw = 1;
      w = 1;
      @(posedge i_clk);
      {i_awvalid, i_wvalid, i_bready} <= 3'h7;
      i_awaddr <= a;
      i_wdata <= d;
      i_wstrb <= 4'hf;
      while (aw || w) begin
         @(posedge i_clk);
         if (o_awready === 1'b1) begin aw = 0; i_awvalid <= 1'b0; end
         if (o_wready === 1'b1) begin w = 0; i_wvalid <= 1'b0; end
      end
      do @(posedge i_clk); while (o_bvalid !== 1'b1);
      i_bready <= 1'b0;
      cmp({30'h0, o_bresp}, {30'h0, want}, "bresp");
   endtask
   task automatic rd(input logic [3:0] a, output logic [QW-1:0] d,
                     output logic [1:0] r);
      @(posedge i_clk);
      {i_arvalid, i_rready} <= 2'h3;
      i_araddr <= a;
      do @(posedge i_clk); while (o_arready !== 1'b1);
      i_arvalid <= 1'b0;
      do @(posedge i_clk); while (o_rvalid !== 1'b1);
      d = o_rdata;
      r = o_rresp;
      i_rready <= 1'b0;
   endtask
   // One packet in, drained concurrently; stall lets the FIFO fill first
   task automatic pkt(input logic [3:0] tc, input logic [1:0] rt, sp,
                      input logic [15:0] n, input int stall);
      logic [QW-1:0] w;
      logic [1:0]    r;
      logic [15:0]   ofu;
      bit            blk, pay;
      ofu = 16'hf5a0;
      blk = tc inside {TC_WR_BLOCK, TC_RD_BLOCK, TC_RDB_RESP, TC_LOCK_REQ,
                       TC_LOCK_RESP};
      pay = blk && tc != TC_RD_BLOCK && n != 0;
      exq = {};
      exq.push_back({10'h2c5, 6'h1b, 2'h1, tc, rt, tc, 4'h0});
      exq.push_back({16'hc3a1, tc == TC_LOCK_RESP ? {ofu[15:12], 12'h0}
                                                   : ofu});
      exq.push_back(32'h89abcde0);
      if (tc == TC_WR_QUAD || tc == TC_RDQ_RESP)
         exq.push_back(32'h13572468);
      if (blk) exq.push_back({n, 16'h0002});
      for (int i = 0; pay && i < n; i += 4) begin
         w = '0;
         for (int b = 0; b < 4; b++)
            if (i + b < n)
               w[31-8*b -: 8] = 8'h10 + i[7:0] + b[7:0];
         exq.push_back(w);
      end
      exq.push_back({14'h0, sp == 2'h3 ? 2'h0 : sp, 12'h0,
                     {2'h0, rt} ^ 4'h5});
      fork
         begin
            @(posedge i_clk);
            i_pkt_valid <= 1'b1;
            i_bus_number <= 10'h2c5;
            i_node_number <= 6'h1b;
            i_transaction_label <= {2'h1, tc};
            i_retry_code <= rt;
            i_transaction_code <= tc;
            i_priority <= 4'h0;
            i_sender_node_ident <= 16'hc3a1;
            i_target_offset_upper <= ofu;
            i_target_offset_lower <= 32'h89abcde0;
            i_quadlet_data <= 32'h13572468;
            i_payload_byte_count <= n;
            i_block_operation_code <= 16'h0002;
            i_speed <= sp;
            i_returned_acknowledge <= {2'h0, rt} ^ 4'h5;
            do @(posedge i_clk); while (o_pkt_ready !== 1'b1);
            i_pkt_valid <= 1'b0;
            for (int i = 0; pay && i < n; i++) begin
               i_byte <= 8'h10 + i[7:0];
               i_byte_valid <= 1'b1;
               do @(posedge i_clk); while (o_byte_ready !== 1'b1);
            end
            i_byte_valid <= 1'b0;
         end
         begin
            repeat (stall) @(posedge i_clk);
            if (stall > 0) cmp({31'h0, o_byte_ready}, '0, "full stall");
            foreach (exq[j]) begin
               do rd(REG_STATUS, w, r); while (w[0] !== 1'b1);
               cmp({31'h0, w[1]}, j == exq.size() - 1, "last");
               rd(REG_DATA, w, r);
               cmp(w, exq[j], "quadlet");
            end
            rd(REG_STATUS, w, r);
            cmp({31'h0, w[0]}, '0, "drained");
         end
      join
   endtask
   task automatic t_regs;
      logic [QW-1:0] d;
      logic [1:0]    r;
      rd(REG_CTRL, d, r);
      cmp(d, '0, "ctrl reset");
      rd(REG_LABEL, d, r);
      cmp(d, '0, "label reset");
      rd(4'h2, d, r);
      cmp({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
      rd(REG_DATA, d, r);
      cmp(d, '0, "data while off");
      wr(REG_STATUS, 32'h1, RESP_SLVERR);
      wr(4'h6, 32'h1, RESP_SLVERR);
      wr(REG_CTRL, 32'h1, RESP_OKAY);
      rd(REG_CTRL, d, r);
      cmp({31'h0, d[0]}, 32'h1, "ctrl enable");
      $display("t_regs done");
   endtask
   task automatic t_quad;
      logic [3:0] tcs[4];
      tcs = '{TC_WR_QUAD, TC_RD_QUAD, TC_RDQ_RESP, 4'h2};
      // Every retry and speed code, speed 3 included
      for (int k = 0; k < 4; k++)
         pkt(tcs[k], k[1:0], k[1:0], 16'h4, 0);
      $display("t_quad done");
   endtask
   task automatic t_block;
      logic [QW-1:0] d;
      logic [1:0]    r;
      pkt(TC_WR_BLOCK, 2'h0, 2'h2, 16'h5, 0);
      pkt(TC_RD_BLOCK, 2'h1, 2'h1, 16'h8, 0);
      pkt(TC_RDB_RESP, 2'h2, 2'h0, 16'h4, 0);
      pkt(TC_LOCK_REQ, 2'h3, 2'h2, 16'h0, 0);
      wr(REG_LABEL, {26'h0, 2'h1, TC_LOCK_RESP}, RESP_OKAY);
      pkt(TC_LOCK_RESP, 2'h0, 2'h1, 16'h8, 0);
      rd(REG_STATUS, d, r);
      cmp(d & 32'h0f04, 32'h0f04, "label and rcode");
      $display("t_block done");
   endtask
   task automatic t_fill;
      pkt(TC_WR_BLOCK, 2'h3, 2'h2, 16'hd, 30);
      $display("t_fill done");
   endtask
   // Main sequence
   initial begin
      {i_pkt_valid, i_byte_valid, i_awvalid, i_wvalid} = '0;
      {i_bready, i_arvalid, i_rready, i_awaddr, i_wstrb, i_araddr} = '0;
      {i_bus_number, i_node_number, i_transaction_label, i_retry_code} = '0;
      {i_transaction_code, i_priority, i_sender_node_ident} = '0;
      {i_target_offset_upper, i_payload_byte_count, i_wdata} = '0;
      {i_block_operation_code, i_target_offset_lower, i_quadlet_data} = '0;
      {i_speed, i_returned_acknowledge, i_byte} = '0;
      repeat (16) @(posedge i_clk);
      cmp({31'h0, o_pkt_ready}, '0, "ready in reset");
      i_rstn <= 1'b1;
      t_regs();
      t_quad();
      t_block();
      t_fill();
      complete_run();
   end
   // Watchdog, well above the several hundred cycles the tests need
   initial begin
      repeat (40000) @(posedge i_clk);
      failures++;
      $display("unexpected %0t watchdog expired", $time);
      complete_run();
   end
endmodule // async_receive_packet_formatter_tb_top
`default_nettype wire
